// ### src/sas_sar_adc_sequencer.sv
`timescale 1ns/10ps
module sas_sar_adc_sequencer (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire sas_pkg::sas_bus_req_t bus_req,
  output logic [7:0]                 rd_data,
  input  wire logic                  comparator_ge,
  input  wire logic                  trigger_pin_input,
  input  wire logic [1:0]            edge_mode_register,
  output logic [7:0]                 ladder_tap,
  output logic [2:0]                 channel_sel,
  output logic                       sample_en,
  output logic                       converter_busy,
  output logic                       conversion_done_irq,
  output logic                       trigger_edge_irq,
  output logic                       shared_irq_req
);

  // ==========================================================================
  // State
  sas_pkg::sas_mode_t  converter_mode_register;
  sas_pkg::sas_state_t state;
  logic [7:0]          approximation_register;
  logic [7:0]          conversion_result_register;
  logic [7:0]          cnt;
  logic [2:0]          bit_idx;
  logic [2:0]          scan_ch;

  sas_pkg::sas_state_t next_state;
  logic [7:0]          next_sar;
  logic [7:0]          next_cnt;
  logic [2:0]          next_bit;
  logic [2:0]          next_scan_ch;
  logic                do_start;
  logic                conv_done;

  logic                trig_edge;
  logic [7:0]          resolved;

  // ==========================================================================
  // Interval lengths, minus one, for the selected speed
  function automatic logic [7:0] bit_reload(input logic speed);
    bit_reload = (speed ? sas_pkg::FAST_BIT_CYC : sas_pkg::SLOW_BIT_CYC) - 8'h01;
  endfunction

  function automatic logic [7:0] smp_reload(input logic speed);
    smp_reload = (speed ? sas_pkg::FAST_SMP_CYC : sas_pkg::SLOW_SMP_CYC) - 8'h01;
  endfunction

  // Register address match, shared by every decode below
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    addr_hit = (addr == target);
  endfunction

  // ==========================================================================
  // Trigger pin edge detector
  sas_edge_detect u_edge (
    .mclk       (mclk),
    .rst        (rst),
    .pin        (trigger_pin_input),
    .edge_mode  (edge_mode_register),
    .edge_pulse (trig_edge)
  );

  // ==========================================================================
  // Register bus decode
  wire                 mode_wr   = bus_req.wr && addr_hit(bus_req.addr, sas_pkg::MODE_ADDR);
  wire                 mode_rd   = bus_req.rd && addr_hit(bus_req.addr, sas_pkg::MODE_ADDR);
  wire                 result_rd = bus_req.rd && addr_hit(bus_req.addr, sas_pkg::RESULT_ADDR);
  wire sas_pkg::sas_mode_t wr_mode = sas_pkg::sas_mode_t'(bus_req.wdata & sas_pkg::MODE_WMASK);
  wire sas_pkg::sas_mode_t next_mode = mode_wr ? wr_mode : converter_mode_register;
  wire [7:0]           rd_value  = mode_rd   ? converter_mode_register :
                                   result_rd ? conversion_result_register :
                                   sas_pkg::RD_UNMAPPED;

  // ==========================================================================
  // Conditions from the mode, the interval counter and the bit under test
  wire running      = converter_mode_register.run;
  wire trig_ok      = running && converter_mode_register.trig_en && trig_edge;
  wire at_end       = (cnt == 8'h00);
  wire last_bit     = (bit_idx == 3'h0);
  wire scan_wrap    = (scan_ch >= converter_mode_register.chan);
  wire done_allowed = !converter_mode_register.chan_mode ||
                      converter_mode_register.trig_en;
  wire done_route   = running && done_allowed;

  // ==========================================================================
  // Trial and decision per bit; the bit under test takes the comparator
  // answer and the next lower bit becomes the new trial
  genvar gi;
  generate
    for (gi = 0; gi < sas_pkg::NUM_BITS; gi++) begin : g_bit
      wire is_cur  = (bit_idx == 3'(gi));
      wire is_next = !last_bit && (3'(bit_idx - 3'h1) == 3'(gi));
      assign resolved[gi] = is_cur  ? comparator_ge :
                            is_next ? 1'b1          :
                            approximation_register[gi];
    end
  endgenerate

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    next_state   = state;
    next_sar     = approximation_register;
    next_cnt     = at_end ? cnt : cnt - 8'h01;
    next_bit     = bit_idx;
    next_scan_ch = scan_ch;
    do_start     = 1'b0;
    conv_done    = 1'b0;
    if (mode_wr) begin
      if (!wr_mode.run) begin
        next_state = sas_pkg::ST_IDLE;
      end else if (wr_mode.trig_en) begin
        next_state = sas_pkg::ST_WAIT;
      end else begin
        do_start = 1'b1;
      end
    end else begin
      case (state)
        sas_pkg::ST_IDLE: begin
          next_state = sas_pkg::ST_IDLE;
        end
        sas_pkg::ST_WAIT: begin
          if (trig_ok) begin
            do_start = 1'b1;
          end
        end
        sas_pkg::ST_SAMPLE: begin
          if (trig_ok) begin
            do_start = 1'b1;
          end else if (at_end) begin
            next_state = sas_pkg::ST_CONVERT;
            next_cnt   = bit_reload(converter_mode_register.speed);
            next_bit   = sas_pkg::MSB_INDEX;
          end
        end
        sas_pkg::ST_CONVERT: begin
          if (trig_ok) begin
            do_start = 1'b1;
          end else if (at_end) begin
            next_sar = resolved;
            if (last_bit) begin
              conv_done  = 1'b1;
              next_state = sas_pkg::ST_SAMPLE;
              next_sar   = sas_pkg::SAR_START;
              next_cnt   = smp_reload(converter_mode_register.speed);
              next_scan_ch = scan_wrap ? 3'h0 : 3'(scan_ch + 3'h1);
            end else begin
              next_bit = 3'(bit_idx - 3'h1);
              next_cnt = bit_reload(converter_mode_register.speed);
            end
          end
        end
        default: begin
          next_state = sas_pkg::ST_IDLE;
        end
      endcase
    end
    if (do_start) begin
      next_state   = sas_pkg::ST_SAMPLE;
      next_sar     = sas_pkg::SAR_START;
      next_cnt     = smp_reload(next_mode.speed);
      next_bit     = sas_pkg::MSB_INDEX;
      next_scan_ch = 3'h0;
    end
  end

  // ==========================================================================
  // Output decode
  wire [2:0] next_chan    = next_mode.chan_mode ? next_mode.chan : next_scan_ch;
  wire       next_done    = conv_done && done_allowed;
  wire       next_shared  = done_route ? next_done : trig_edge;
  wire       next_busy    = (next_state == sas_pkg::ST_SAMPLE) ||
                            (next_state == sas_pkg::ST_CONVERT);
  wire       next_sample  = (next_state == sas_pkg::ST_SAMPLE);

  // ==========================================================================
  // Mode register
  always_ff @(posedge mclk) begin
    if (rst) begin
      converter_mode_register <= sas_pkg::sas_mode_t'(sas_pkg::MODE_RESET);
    end else if (mode_wr) begin
      converter_mode_register <= wr_mode;
    end
  end

  // ==========================================================================
  // Sequencer state
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= sas_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Approximation register
  always_ff @(posedge mclk) begin
    if (rst) begin
      approximation_register <= 8'h00;
    end else begin
      approximation_register <= next_sar;
    end
  end

  // ==========================================================================
  // Interval counter and bit under test
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt     <= 8'h00;
      bit_idx <= 3'h0;
    end else begin
      cnt     <= next_cnt;
      bit_idx <= next_bit;
    end
  end

  // ==========================================================================
  // Scan position
  always_ff @(posedge mclk) begin
    if (rst) begin
      scan_ch <= 3'h0;
    end else begin
      scan_ch <= next_scan_ch;
    end
  end

  // ==========================================================================
  // Result register: no reset, loaded only by a completed conversion
  always_ff @(posedge mclk) begin
    if (conv_done) begin
      conversion_result_register <= resolved;
    end
  end

  // ==========================================================================
  // Read data, held until the next read strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data <= sas_pkg::RD_UNMAPPED;
    end else if (bus_req.rd) begin
      rd_data <= rd_value;
    end
  end

  // ==========================================================================
  // Ladder tap code
  always_ff @(posedge mclk) begin
    if (rst) begin
      ladder_tap <= 8'h00;
    end else begin
      ladder_tap <= next_sar;
    end
  end

  // ==========================================================================
  // Input channel in use
  always_ff @(posedge mclk) begin
    if (rst) begin
      channel_sel <= 3'h0;
    end else begin
      channel_sel <= next_chan;
    end
  end

  // ==========================================================================
  // Conversion phase flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_en      <= 1'b0;
      converter_busy <= 1'b0;
    end else begin
      sample_en      <= next_sample;
      converter_busy <= next_busy;
    end
  end

  // ==========================================================================
  // Conversion-done request
  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_done_irq <= 1'b0;
    end else begin
      conversion_done_irq <= next_done;
    end
  end

  // ==========================================================================
  // Trigger-pin request
  always_ff @(posedge mclk) begin
    if (rst) begin
      trigger_edge_irq <= 1'b0;
    end else begin
      trigger_edge_irq <= trig_edge;
    end
  end

  // ==========================================================================
  // Shared request line
  always_ff @(posedge mclk) begin
    if (rst) begin
      shared_irq_req <= 1'b0;
    end else begin
      shared_irq_req <= next_shared;
    end
  end

endmodule // sas_sar_adc_sequencer

// ### src/sas_pkg.sv
package sas_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] MODE_ADDR   = 16'hFF68;
  localparam logic [15:0] RESULT_ADDR = 16'hFF6A;
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [7:0]  MODE_WMASK  = 8'hDF;
  localparam logic [7:0]  RD_UNMAPPED = 8'h00;

  // ==========================================================================
  // Conversion timing in system states (one state per mclk cycle)
  localparam int          NUM_BITS     = 8;
  localparam int          SLOW_STATES  = 180;
  localparam int          FAST_STATES  = 120;
  // Bit interval taken from (states - 1) so the sampling phase is never empty
  localparam int          SLOW_BIT_LEN = (SLOW_STATES - 1) / NUM_BITS;
  localparam int          FAST_BIT_LEN = (FAST_STATES - 1) / NUM_BITS;
  localparam logic [7:0]  SLOW_BIT_CYC = 8'(SLOW_BIT_LEN);
  localparam logic [7:0]  FAST_BIT_CYC = 8'(FAST_BIT_LEN);
  localparam logic [7:0]  SLOW_SMP_CYC = 8'(SLOW_STATES - NUM_BITS * SLOW_BIT_LEN);
  localparam logic [7:0]  FAST_SMP_CYC = 8'(FAST_STATES - NUM_BITS * FAST_BIT_LEN);
  localparam logic [7:0]  SAR_START    = 8'h80;
  localparam logic [2:0]  MSB_INDEX    = 3'h7;

  // ==========================================================================
  // Trigger edge selection
  localparam logic [1:0]  EDGE_FALLING = 2'h0;
  localparam logic [1:0]  EDGE_RISING  = 2'h1;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic       run;
    logic       trig_en;
    logic       rsvd;
    logic       speed;
    logic [2:0] chan;
    logic       chan_mode;
  } sas_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } sas_bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_WAIT    = 2'b01,
    ST_SAMPLE  = 2'b10,
    ST_CONVERT = 2'b11
  } sas_state_t;

endpackage

// ### src/sas_edge_detect.sv
`timescale 1ns/10ps
module sas_edge_detect (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] edge_mode,
  output logic            edge_pulse
);

  logic primed;
  logic pin_q;

  // ==========================================================================
  // Edge decode
  wire rise     = primed && pin && !pin_q;
  wire fall     = primed && !pin && pin_q;
  wire both_sel = edge_mode[1];
  wire hit      = both_sel ? (rise || fall) :
                  (edge_mode == sas_pkg::EDGE_RISING) ? rise : fall;

  // ==========================================================================
  // Pin history; first cycle after reset only primes the history
  always_ff @(posedge mclk) begin
    if (rst) begin
      primed     <= 1'b0;
      pin_q      <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      primed     <= 1'b1;
      pin_q      <= pin;
      edge_pulse <= hit;
    end
  end

endmodule // sas_edge_detect

// ### verif/sas_analog_model.sv
`timescale 1ns/10ps
// ==========
// Comparator against one fixed level per input channel
module sas_analog_model (
  input  wire logic [7:0] ladder_tap,
  input  wire logic [2:0] channel_sel,
  output logic            comparator_ge
);
  wire logic [7:0] level = 8'h13 + 8'h21 * {5'h00, channel_sel};
  assign comparator_ge = level >= ladder_tap;
endmodule // sas_analog_model

// ### verif/sas_seq_assertions.sv
`timescale 1ns/10ps
module sas_seq_checker (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire sas_pkg::sas_bus_req_t bus_req,
  input wire logic                  comparator_ge,
  input wire logic                  trigger_pin_input,
  input wire logic [1:0]            edge_mode_register,
  input wire logic [7:0]            ladder_tap,
  input wire logic [2:0]            channel_sel,
  input wire logic                  sample_en,
  input wire logic                  converter_busy,
  input wire logic                  conversion_done_irq,
  input wire logic                  trigger_edge_irq,
  input wire logic                  shared_irq_req
);
  // ==========
  // Mode mirror, cycles since start, previous trial
  sas_pkg::sas_mode_t mode_q;
  logic [7:0]         cnt;
  logic [7:0]         tap_q;
  logic               cmp_q;
  wire wr_mode = bus_req.wr && bus_req.addr == sas_pkg::MODE_ADDR;
  wire [7:0] trial = tap_q & (~tap_q + 8'h01);
  wire [7:0] exp_tap = (tap_q & ~trial) | (cmp_q ? trial : 8'h00) | (trial >> 1);
  always_ff @(posedge mclk) begin
    tap_q <= ladder_tap;
    cmp_q <= comparator_ge;
    if (rst) begin
      mode_q <= sas_pkg::sas_mode_t'(sas_pkg::MODE_RESET);
      cnt    <= 8'h00;
    end else begin
      if (wr_mode) mode_q <= sas_pkg::sas_mode_t'(bus_req.wdata & sas_pkg::MODE_WMASK);
      if (wr_mode) cnt <= 8'h00;
      else if (conversion_done_irq) cnt <= 8'h01;
      else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========
  // Properties
  sequence s_run_wr;
    wr_mode && bus_req.wdata[7] && !bus_req.wdata[6];
  endsequence
  sequence s_stop_wr;
    wr_mode && !bus_req.wdata[7];
  endsequence
  property p_start;
    s_run_wr |=> ladder_tap == sas_pkg::SAR_START && sample_en && converter_busy;
  endproperty
  property p_stop;
    s_stop_wr |=> (!converter_busy && !conversion_done_irq)[*4];
  endproperty
  property p_trial;
    converter_busy && !sample_en && ladder_tap != tap_q |-> ladder_tap == exp_tap;
  endproperty
  property p_period;
    conversion_done_irq && !mode_q.trig_en
      |-> int'(cnt) == (mode_q.speed ? sas_pkg::FAST_STATES : sas_pkg::SLOW_STATES);
  endproperty
  property p_silent;
    mode_q.run && mode_q.chan_mode && !mode_q.trig_en |-> !conversion_done_irq;
  endproperty
  property p_chan;
    converter_busy && mode_q.chan_mode |-> channel_sel == mode_q.chan;
  endproperty
  property p_shared;
    !mode_q.run && !$past(mode_q.run) |-> shared_irq_req == trigger_edge_irq;
  endproperty
  property p_edge;
    $rose(trigger_pin_input) && edge_mode_register == sas_pkg::EDGE_RISING
      |-> ##[1:2] trigger_edge_irq;
  endproperty
  a_start: assert property (p_start) else $error("start tap wrong");
  a_stop: assert property (p_stop) else $error("stop not silent");
  a_trial: assert property (p_trial) else $error("trial step wrong");
  a_period: assert property (p_period) else $error("length wrong");
  a_silent: assert property (p_silent) else $error("done in single");
  a_chan: assert property (p_chan) else $error("channel wrong");
  a_shared: assert property (p_shared) else $error("shared wrong");
  a_edge: assert property (p_edge) else $error("edge missed");
endmodule // sas_seq_checker

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic                  mclk, rst, comparator_ge, trigger_pin_input;
  sas_pkg::sas_bus_req_t bus_req;
  logic [1:0]            edge_mode_register;
  logic [7:0]            rd_data, ladder_tap, v, n, s;
  logic [2:0]            channel_sel;
  logic                  sample_en, converter_busy, conversion_done_irq;
  logic                  trigger_edge_irq, shared_irq_req;
  int                    bad_count, n_checks, k, cyc;
  localparam logic [15:0] MA = sas_pkg::MODE_ADDR;
  localparam logic [15:0] RA = sas_pkg::RESULT_ADDR;
  sas_sar_adc_sequencer DUT (.mclk, .rst, .bus_req, .rd_data, .comparator_ge,
    .trigger_pin_input, .edge_mode_register, .ladder_tap, .channel_sel, .sample_en,
    .converter_busy, .conversion_done_irq, .trigger_edge_irq, .shared_irq_req);
  sas_analog_model u_ana (.ladder_tap, .channel_sel, .comparator_ge);
  // ==========
  // Tasks
  function automatic logic [7:0] ain(input logic [2:0] c);
    return 8'h13 + 8'h21 * {5'h00, c};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_req = '{a, 1'b1, 1'b0, d};
    @(negedge mclk);
    bus_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    bus_req.addr = a;
    bus_req.rd = 1'b1;
    @(negedge mclk);
    bus_req.rd = 1'b0;
    d = rd_data;
  endtask
  task automatic wait_done(input int lim);
    k = 1;
    while (conversion_done_irq !== 1'b1 && k < lim) begin
      @(negedge mclk);
      k++;
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc == 20000) begin
        bad_count++;
        end_sim();
      end
    end
  end
  // ==========
  // Scenarios
  initial begin
    rst = 1'b1;
    bus_req = '0;
    trigger_pin_input = 1'b0;
    edge_mode_register = sas_pkg::EDGE_RISING;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rd(MA, v);
    chk(v, 8'h00);
    wr(MA, 8'hFF);
    rd(MA, v);
    chk(v, 8'hDF);
    wr(MA, 8'h12);
    wr(MA, 8'h92);
    wait_done(200);
    chk(k[7:0], 8'h79);
    rd(RA, v);
    chk(v, ain(3'h0));
    for (int i = 1; i < 4; i++) begin
      wait_done(200);
      rd(RA, v);
      chk(v, ain(3'(i % 2)));
    end
    wr(RA, 8'h00);
    rd(RA, v);
    chk(v, ain(3'h1));
    rd(16'hFF60, v);
    chk(v, sas_pkg::RD_UNMAPPED);
    wr(MA, 8'h80);
    fork
      begin
        repeat (60) @(negedge mclk);
        trigger_pin_input = 1'b1;
      end
    join_none
    wait_done(250);
    chk(k[7:0], 8'hB5);
    wr(MA, 8'h90);
    repeat (50) @(negedge mclk);
    wr(MA, 8'h90);
    wait_done(200);
    chk(k[7:0], 8'h79);
    repeat (50) @(negedge mclk);
    wr(MA, 8'h10);
    wait_done(250);
    chk(k[7:0], 8'hFA);
    chk({7'h00, converter_busy}, 8'h00);
    wr(MA, 8'h8B);
    wait_done(250);
    chk(k[7:0], 8'hFA);
    rd(RA, v);
    chk(v, ain(3'h5));
    wr(MA, 8'hCB);
    repeat (100) @(negedge mclk);
    chk({7'h00, converter_busy}, 8'h00);
    trigger_pin_input = 1'b0;
    repeat (3) @(negedge mclk);
    trigger_pin_input = 1'b1;
    repeat (60) @(negedge mclk);
    chk({7'h00, converter_busy}, 8'h01);
    trigger_pin_input = 1'b0;
    repeat (3) @(negedge mclk);
    trigger_pin_input = 1'b1;
    wait_done(250);
    chk(k[7:0], 8'hB7);
    trigger_pin_input = 1'b0;
    wr(MA, 8'h00);
    for (int m = 0; m < 3; m++) begin
      edge_mode_register = 2'(m);
      n = 8'h00;
      s = 8'h00;
      for (int j = 0; j < 16; j++) begin
        trigger_pin_input = j >= 4 && j < 10;
        @(negedge mclk);
        n = n + {7'h00, trigger_edge_irq};
        s = s + {7'h00, shared_irq_req};
      end
      chk(n, (m == 2) ? 8'h02 : 8'h01);
      chk(s, n);
    end
    end_sim();
  end
endmodule // tb
bind sas_sar_adc_sequencer sas_seq_checker u_chk (.mclk, .rst, .bus_req, .comparator_ge,
  .trigger_pin_input, .edge_mode_register, .ladder_tap, .channel_sel, .sample_en,
  .converter_busy, .conversion_done_irq, .trigger_edge_irq, .shared_irq_req);
